// file: common/tdcf_params.svh
`ifndef TDCF_PARAMS_SVH
`define TDCF_PARAMS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define TDCF_BUF_LAST_ADDR   16'h0FFC
`define TDCF_SLOT_ADDR       16'h1002
`define TDCF_SLOT_RESET      5'h1F
// ----------------------------------------------------------------
// buffer word fields
// ----------------------------------------------------------------
`define TDCF_TYPE_HEADER     3'h2
`define TDCF_TYPE_DATUM      3'h0
`define TDCF_TYPE_EOE        3'h4
`define TDCF_TYPE_FILLER     3'h6
`define TDCF_SLOT_MSB        31
`define TDCF_SLOT_LSB        27
`define TDCF_TYPE_MSB        26
`define TDCF_TYPE_LSB        24
`define TDCF_CRATE_LSB       16
`define TDCF_COUNT_LSB       8
`define TDCF_CH32_LSB        16
`define TDCF_CH16_LSB        17
`define TDCF_VALID_BIT       14
`define TDCF_UNDER_BIT       13
`define TDCF_OVER_BIT        12
// ----------------------------------------------------------------
// keep controls in the second bit-set word
// ----------------------------------------------------------------
`define TDCF_KEEP_INV_BIT    5
`define TDCF_KEEP_UNDER_BIT  4
`define TDCF_KEEP_OVER_BIT   3
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define TDCF_MEM_WORDS       1024
`define TDCF_LAST_CH32       5'h1F
`define TDCF_LAST_CH16       5'h0F
`endif

// file: common/tdcf_pkg.sv
`default_nettype none
package tdcf_pkg;
  typedef struct packed {
    logic        kill;
    logic        valid;
    logic        under;
    logic        over;
    logic [11:0] value;
  } tdcf_chan_s;

  typedef struct packed {
    logic        last;
    logic [31:0] word;
  } tdcf_entry_s;

  typedef enum logic [1:0] {
    TDCF_IDLE = 2'b00,
    TDCF_HEAD = 2'b01,
    TDCF_DATA = 2'b10,
    TDCF_EOE  = 2'b11
  } tdcf_state_e;
endpackage : tdcf_pkg
`default_nettype wire

// file: hdl/tdcf_formatter.sv
`timescale 1ns/1ps
`default_nettype none
`include "tdcf_params.svh"
module tdcf_formatter #(
  parameter bit HAS_AUX = 1'b1,
  parameter bit CH16    = 1'b0
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_b,
  input  wire logic                      module_reset,
  input  wire logic [4:0]                backplane_slot,
  input  wire logic                      conv_valid,
  output logic                           conv_ready,
  input  wire tdcf_pkg::tdcf_chan_s [31:0] conv_chan,
  input  wire logic [15:0]               bit_set2,
  input  wire logic                      zero_supp_en,
  input  wire logic [7:0]                crate_id,
  input  wire logic [23:0]               event_count,
  input  wire logic [15:0]               reg_addr,
  input  wire logic                      reg_rd,
  input  wire logic                      reg_wr,
  input  wire logic [15:0]               reg_wdata,
  output logic [31:0]                    reg_rdata,
  output logic                           reg_ack,
  output logic                           no_slot_code_flag,
  output logic [4:0]                     slot_code
);
  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic keep_ch(input tdcf_pkg::tdcf_chan_s c,
                                   input logic [15:0] bs);
    keep_ch = !c.kill
              && (c.valid || bs[`TDCF_KEEP_INV_BIT])
              && (!c.under || bs[`TDCF_KEEP_UNDER_BIT])
              && (!c.over || bs[`TDCF_KEEP_OVER_BIT]);
  endfunction : keep_ch

  // slot index 2k reads channel k, 2k+1 reads channel k plus half
  function automatic logic [4:0] chan_of(input logic [5:0] i);
    logic [4:0] half;
    half = CH16 ? 5'h08 : 5'h10;
    chan_of = i[0] ? (i[5:1] + half) : i[5:1];
  endfunction : chan_of

  function automatic logic [31:0] tag(input logic [4:0] s, input logic [2:0] t);
    tag = 32'h0000_0000;
    tag[`TDCF_SLOT_MSB:`TDCF_SLOT_LSB] = s;
    tag[`TDCF_TYPE_MSB:`TDCF_TYPE_LSB] = t;
  endfunction : tag

  // ----------------------------------------------------------------
  // channel selection
  // ----------------------------------------------------------------
  logic [31:0] kept;
  logic [5:0]  kept_cnt;
  always_comb begin
    kept     = 32'h0000_0000;
    kept_cnt = 6'h00;
    for (int i = 0; i < 32; i++) begin
      kept[i]  = keep_ch(conv_chan[i], bit_set2) && (!CH16 || i < 16);
      kept_cnt = kept_cnt + {5'h00, kept[i]};
    end
  end

  // ----------------------------------------------------------------
  // formatter state machine
  // ----------------------------------------------------------------
  tdcf_pkg::tdcf_state_e       st;
  tdcf_pkg::tdcf_chan_s [31:0] lat_chan;
  logic [31:0]                 lat_mask;
  logic [5:0]                  lat_cnt;
  logic [5:0]                  idx;
  logic [7:0]                  lat_crate;
  logic [23:0]                 lat_evc;
  logic                        fmt_valid;
  logic                        fmt_ready;
  logic [31:0]                 fmt_word;
  logic                        fmt_last;
  logic [4:0]                  cur_ch;
  logic                        last_idx;

  assign conv_ready = (st == tdcf_pkg::TDCF_IDLE);
  assign cur_ch     = chan_of(idx);
  assign last_idx   = (idx[4:0] == (CH16 ? `TDCF_LAST_CH16 : `TDCF_LAST_CH32));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st        <= tdcf_pkg::TDCF_IDLE;
      lat_chan  <= '0;
      lat_mask  <= 32'h0000_0000;
      lat_cnt   <= 6'h00;
      idx       <= 6'h00;
      lat_crate <= 8'h00;
      lat_evc   <= 24'h00_0000;
    end else begin
      unique case (st)
        tdcf_pkg::TDCF_IDLE: begin
          // empty gate under zero suppression leaves the pointer alone
          if (conv_valid && !(zero_supp_en && kept_cnt == 6'h00)) begin
            st        <= tdcf_pkg::TDCF_HEAD;
            lat_chan  <= conv_chan;
            lat_mask  <= kept;
            lat_cnt   <= kept_cnt;
            lat_crate <= crate_id;
            lat_evc   <= event_count;
          end
        end
        tdcf_pkg::TDCF_HEAD: begin
          if (fmt_ready) begin
            st  <= tdcf_pkg::TDCF_DATA;
            idx <= 6'h00;
          end
        end
        tdcf_pkg::TDCF_DATA: begin
          // a skipped channel costs a cycle but never waits on the buffer
          if (!lat_mask[cur_ch] || fmt_ready) begin
            idx <= idx + 6'h01;
            if (last_idx) begin
              st <= tdcf_pkg::TDCF_EOE;
            end
          end
        end
        tdcf_pkg::TDCF_EOE: begin
          if (fmt_ready) begin
            st <= tdcf_pkg::TDCF_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    fmt_valid = 1'b0;
    fmt_last  = 1'b0;
    fmt_word  = 32'h0000_0000;
    unique case (st)
      tdcf_pkg::TDCF_IDLE: begin
        fmt_valid = 1'b0;
      end
      tdcf_pkg::TDCF_HEAD: begin
        fmt_valid = 1'b1;
        fmt_word  = tag(slot_code, `TDCF_TYPE_HEADER);
        fmt_word[23:`TDCF_CRATE_LSB] = lat_crate;
        fmt_word[13:`TDCF_COUNT_LSB] = lat_cnt;
      end
      tdcf_pkg::TDCF_DATA: begin
        fmt_valid = lat_mask[cur_ch];
        fmt_word  = tag(slot_code, `TDCF_TYPE_DATUM);
        if (CH16) begin
          fmt_word[20:`TDCF_CH16_LSB] = cur_ch[3:0];
        end else begin
          fmt_word[20:`TDCF_CH32_LSB] = cur_ch;
        end
        fmt_word[`TDCF_VALID_BIT] = lat_chan[cur_ch].valid;
        fmt_word[`TDCF_UNDER_BIT] = lat_chan[cur_ch].under;
        fmt_word[`TDCF_OVER_BIT]  = lat_chan[cur_ch].over;
        fmt_word[11:0]            = lat_chan[cur_ch].value;
      end
      tdcf_pkg::TDCF_EOE: begin
        fmt_valid     = 1'b1;
        fmt_last      = 1'b1;
        fmt_word      = tag(slot_code, `TDCF_TYPE_EOE);
        fmt_word[23:0] = lat_evc;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // two-entry buffer toward the event memory
  // ----------------------------------------------------------------
  tdcf_pkg::tdcf_entry_s fq [0:1];
  logic                  fq_wp;
  logic                  fq_rp;
  logic [1:0]            fq_cnt;
  logic                  fq_out_valid;
  logic                  fq_out_ready;
  logic                  fq_push;
  logic                  fq_pop;

  assign fmt_ready    = (fq_cnt != 2'h2);
  assign fq_out_valid = (fq_cnt != 2'h0);
  assign fq_push      = fmt_valid && fmt_ready;
  assign fq_pop       = fq_out_valid && fq_out_ready;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fq[0]  <= '0;
      fq[1]  <= '0;
      fq_wp  <= 1'b0;
      fq_rp  <= 1'b0;
      fq_cnt <= 2'h0;
    end else begin
      if (fq_push) begin
        fq[fq_wp] <= '{last: fmt_last, word: fmt_word};
        fq_wp     <= !fq_wp;
      end
      if (fq_pop) begin
        fq_rp <= !fq_rp;
      end
      fq_cnt <= fq_cnt + {1'b0, fq_push} - {1'b0, fq_pop};
    end
  end

  // ----------------------------------------------------------------
  // event memory
  // ----------------------------------------------------------------
  logic [31:0] mem [0:`TDCF_MEM_WORDS-1];
  logic [10:0] wr_ptr;
  logic [10:0] cm_ptr;
  logic [10:0] rd_ptr;
  logic        mem_full;
  logic        mem_empty;

  assign mem_full     = (wr_ptr == {!rd_ptr[10], rd_ptr[9:0]});
  assign mem_empty    = (rd_ptr == cm_ptr);
  assign fq_out_ready = !mem_full;

  always_ff @(posedge ref_clk) begin
    if (fq_pop) begin
      mem[wr_ptr[9:0]] <= fq[fq_rp].word;
    end
  end

  // words of a partly written event stay hidden until its end word lands
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= 11'h000;
      cm_ptr <= 11'h000;
    end else if (fq_pop) begin
      wr_ptr <= wr_ptr + 11'h001;
      if (fq[fq_rp].last) begin
        cm_ptr <= wr_ptr + 11'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // slot position register
  // ----------------------------------------------------------------
  logic [4:0] slot_stored;
  logic       load_pend;
  logic       buf_hit;
  logic       slot_hit;
  logic       slot_wr_ok;

  assign buf_hit    = (reg_addr <= `TDCF_BUF_LAST_ADDR) && (reg_addr[1:0] == 2'h0);
  assign slot_hit   = (reg_addr == `TDCF_SLOT_ADDR);
  // with the connector present the write is left unanswered
  assign slot_wr_ok = reg_wr && slot_hit && !HAS_AUX;
  assign no_slot_code_flag = !HAS_AUX;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_stored <= `TDCF_SLOT_RESET;
    end else if (slot_wr_ok) begin
      slot_stored <= reg_wdata[4:0];
    end
  end

  // strap level is caught after release, never inside the async reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      load_pend <= 1'b1;
      slot_code <= `TDCF_SLOT_RESET;
    end else begin
      load_pend <= 1'b0;
      if (load_pend || module_reset) begin
        slot_code <= HAS_AUX ? backplane_slot : slot_stored;
      end
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr    <= 11'h000;
      reg_rdata <= 32'h0000_0000;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack <= (reg_rd && (buf_hit || slot_hit)) || slot_wr_ok;
      if (reg_rd && buf_hit) begin
        if (mem_empty) begin
          reg_rdata <= tag(5'h00, `TDCF_TYPE_FILLER);
        end else begin
          reg_rdata <= mem[rd_ptr[9:0]];
          rd_ptr    <= rd_ptr + 11'h001;
        end
      end else if (reg_rd && slot_hit) begin
        reg_rdata <= {27'h000_0000, HAS_AUX ? slot_code : slot_stored};
      end
    end
  end
endmodule : tdcf_formatter
`default_nettype wire

// file: verification/tdcf_formatter_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// port checks
// ----------------------------------------------------------------
module tdcf_formatter_monitor #(
  parameter bit HAS_AUX = 1'b1
) (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        module_reset,
  input wire logic [4:0]  backplane_slot,
  input wire logic        conv_valid,
  input wire logic        conv_ready,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_ack,
  input wire logic        no_slot_code_flag,
  input wire logic [4:0]  slot_code
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    conv_valid && conv_ready ##1 !conv_ready;
  endsequence
  sequence s_buf_read;
    reg_rd && reg_addr <= 16'h0FFC ##1 reg_ack;
  endsequence
  AST_ACK_CAUSE: assert property (reg_ack |-> $past(reg_rd || reg_wr))
    else $error("ack without request");
  AST_SLOT_WR: assert property (HAS_AUX && reg_wr && reg_addr == 16'h1002 |=> !reg_ack)
    else $error("slot write answered");
  AST_UNMAPPED: assert property ((reg_rd || reg_wr) && reg_addr > 16'h1002 |=> !reg_ack)
    else $error("unmapped access answered");
  AST_FLAG: assert property (no_slot_code_flag == !HAS_AUX)
    else $error("slot source flag wrong");
  AST_SLOT_LOAD: assert property (HAS_AUX && module_reset |=> slot_code == $past(backplane_slot))
    else $error("slot not captured");
  AST_SLOT_HOLD: assert property ($past(rst_b, 2) && !$past(module_reset) |-> $stable(slot_code))
    else $error("slot changed without reset");
  AST_EVENT_BUSY: assert property (s_take |-> !conv_ready [*8] ##[25:600] conv_ready)
    else $error("event length wrong");
  AST_TYPE: assert property (s_buf_read |-> reg_rdata[26:24] inside {3'h2, 3'h0, 3'h4, 3'h6})
    else $error("reserved word type");
  AST_FILLER: assert property (s_buf_read ##0 reg_rdata[26:24] == 3'h6 |-> reg_rdata == 32'h0600_0000)
    else $error("filler word wrong");
endmodule : tdcf_formatter_monitor
bind tdcf_formatter tdcf_formatter_monitor #(.HAS_AUX(HAS_AUX)) tdcf_formatter_monitor_i (
  .ref_clk(ref_clk), .rst_b(rst_b), .module_reset(module_reset),
  .backplane_slot(backplane_slot), .conv_valid(conv_valid), .conv_ready(conv_ready),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .reg_ack(reg_ack), .no_slot_code_flag(no_slot_code_flag), .slot_code(slot_code));
`default_nettype wire

// file: verification/tdcf_reader_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// bus master reading the buffer window
// ----------------------------------------------------------------
module tdcf_reader_model (
  input  wire logic        ref_clk,
  input  wire logic        reg_ack,
  input  wire logic [31:0] reg_rdata,
  output logic [15:0]      reg_addr,
  output logic             reg_rd,
  output logic             reg_wr,
  output logic [15:0]      reg_wdata
);
  initial begin
    reg_addr = 16'h0000;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end
  task access(input logic wr, input logic [15:0] a, input logic [15:0] d,
              output logic [31:0] q, output logic ok);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_rd = !wr;
    reg_wr = wr;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    // released lines show garbage, not the last value
    reg_addr = ~a;
    reg_wdata = ~d;
    ok = 1'b0;
    q = 32'h0000_0000;
    repeat (4) begin
      if (reg_ack === 1'b1) begin
        ok = 1'b1;
        q = reg_rdata;
      end
      @(negedge ref_clk);
    end
  endtask : access
endmodule : tdcf_reader_model
`default_nettype wire

// file: verification/tdcf_formatter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tdcf_formatter_tb;
  logic ref_clk, rst_b, module_reset, conv_valid, conv_ready, zero_supp_en;
  logic reg_rd, reg_wr, reg_ack, no_slot_code_flag;
  logic [4:0] backplane_slot, slot_code, exp_slot;
  logic [15:0] bit_set2, reg_addr, reg_wdata;
  logic [7:0] crate_id;
  logic [23:0] event_count;
  logic [31:0] reg_rdata, q;
  // second copy without the slot connector, sharing every input
  logic conv_ready_na, reg_ack_na, no_slot_code_flag_na;
  logic [4:0] slot_code_na;
  logic [31:0] reg_rdata_na;
  tdcf_pkg::tdcf_chan_s [31:0] conv_chan;
  int err_total = 0;
  int tests_run = 0;
  int ready_wait = 0;
  tdcf_formatter tdcf_formatter_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .module_reset(module_reset), .backplane_slot(backplane_slot), .conv_valid(conv_valid),
    .conv_ready(conv_ready), .conv_chan(conv_chan), .bit_set2(bit_set2),
    .zero_supp_en(zero_supp_en), .crate_id(crate_id), .event_count(event_count),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .no_slot_code_flag(no_slot_code_flag),
    .slot_code(slot_code));
  tdcf_formatter #(.HAS_AUX(1'b0)) tdcf_formatter_noaux_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .module_reset(module_reset), .backplane_slot(backplane_slot), .conv_valid(conv_valid),
    .conv_ready(conv_ready_na), .conv_chan(conv_chan), .bit_set2(bit_set2),
    .zero_supp_en(zero_supp_en), .crate_id(crate_id), .event_count(event_count),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata_na), .reg_ack(reg_ack_na),
    .no_slot_code_flag(no_slot_code_flag_na), .slot_code(slot_code_na));
  tdcf_reader_model tdcf_reader_model_i (.ref_clk(ref_clk), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata));
  task conclude;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task acc(input logic wr, input logic [15:0] a, input logic exp_ok);
    logic ok;
    tdcf_reader_model_i.access(wr, a, 16'h0000, q, ok);
    check({31'h0, ok}, {31'h0, exp_ok});
  endtask : acc
  task offer;
    int n;
    @(negedge ref_clk) conv_valid = 1'b1;
    @(negedge ref_clk) conv_valid = 1'b0;
    for (n = 0; n < 200 && conv_ready !== 1'b1; n++) @(negedge ref_clk);
    if (n == 200) begin
      err_total++;
      $display("Error at %0t: event never finished", $time);
      conclude();
    end
    ready_wait = n;
    // commit lands one cycle after ready returns
    repeat (6) @(negedge ref_clk);
  endtask : offer
  // automatic so that the expected queue starts empty on every call
  task automatic t_event(input logic [15:0] bs);
    logic [31:0] exp_q[$];
    logic [4:0] ch;
    logic kept;
    for (int i = 0; i < 32; i++)
      conv_chan[i] = {i == 3, i != 5, i == 6, i == 17, 12'h800 | 12'(i)};
    bit_set2 = bs;
    crate_id = 8'hA5;
    event_count = 24'hFE_DC00 | bs;
    offer();
    check(ready_wait, 32'h0000_0022);
    for (int k = 0; k < 32; k++) begin
      ch = k[0] ? 5'(16 + k / 2) : 5'(k / 2);
      kept = !conv_chan[ch].kill && (conv_chan[ch].valid || bs[5])
             && (!conv_chan[ch].under || bs[4]) && (!conv_chan[ch].over || bs[3]);
      if (kept) exp_q.push_back({exp_slot, 3'h0, 3'h0, ch, 1'b0, conv_chan[ch][14:0]});
    end
    acc(1'b0, 16'h0000, 1'b1);
    check(q, {exp_slot, 3'h2, crate_id, 2'b00, 6'(exp_q.size()), 8'h00});
    foreach (exp_q[j]) begin
      acc(1'b0, 16'(4 * j), 1'b1);
      check(q, exp_q[j]);
    end
    acc(1'b0, 16'h0FFC, 1'b1);
    check(q, {exp_slot, 3'h4, event_count});
    acc(1'b0, 16'h0000, 1'b1);
    check(q, 32'h0600_0000);
  endtask : t_event
  task t_zero;
    zero_supp_en = 1'b1;
    for (int i = 0; i < 32; i++) conv_chan[i].kill = 1'b1;
    offer();
    check({31'h0, conv_ready}, 32'h1);
    check(ready_wait, 32'h0000_0000);
    check({31'h0, conv_ready_na}, 32'h1);
    acc(1'b0, 16'h0000, 1'b1);
    check(q, 32'h0600_0000);
    zero_supp_en = 1'b0;
  endtask : t_zero
  task t_slot;
    logic ok;
    check({31'h0, no_slot_code_flag}, 32'h0);
    check({31'h0, no_slot_code_flag_na}, 32'h1);
    check({27'h0, slot_code_na}, 32'h1F);
    tdcf_reader_model_i.access(1'b1, 16'h1002, 16'h0005, q, ok);
    check({31'h0, ok}, 32'h0);
    check({27'h0, slot_code_na}, 32'h1F);
    acc(1'b0, 16'h1002, 1'b1);
    check(q, {27'h0, exp_slot});
    check(reg_rdata_na, 32'h5);
    acc(1'b0, 16'h1004, 1'b0);
    backplane_slot = 5'h14;
    @(negedge ref_clk) module_reset = 1'b1;
    @(negedge ref_clk) module_reset = 1'b0;
    exp_slot = 5'h14;
    check({27'h0, slot_code}, {27'h0, exp_slot});
    check({27'h0, slot_code_na}, 32'h5);
  endtask : t_slot
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_b, module_reset, conv_valid, zero_supp_en} = 4'h0;
    backplane_slot = 5'h0B;
    exp_slot = 5'h0B;
    conv_chan = '0;
    bit_set2 = 16'h0000;
    crate_id = 8'h00;
    event_count = 24'h00_0000;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk) rst_b = 1'b1;
    acc(1'b0, 16'h0000, 1'b1);
    check(q, 32'h0600_0000);
    t_event(16'h0000);
    t_event(16'h0038);
    t_zero();
    t_slot();
    t_event(16'h0008);
    conclude();
  end
endmodule : tdcf_formatter_tb
`default_nettype wire
